// file: src/basic_timebase_timer.sv
// APB-attached basic timebase timer with buffered prescaler and reload limit.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Sixteen-bit counter that only counts up.
// - Prescaler divides the timer clock by 1 to 65536; its tick advances the counter.
// - The internal timer clock is the only counting source.
// - Counting happens only while the counter run bit is set.
// - Counter climbs from zero; at the reload limit it wraps to zero with overflow.
// - Every update event loads buffered reload and prescale values into active copies.
// - Prescale writes while running wait in a buffer until the next update.
// - Update block bit clear allows updates from overflow, software or slave; set blocks.
// - Source select set lets only overflow raise the update interrupt or DMA.
// - One-shot bit clears the run bit at the next update event.
// - Reload buffer bit clear means reload writes act at once; set waits for update.
// - Control register one resets to zero.
// - Trigger select 000 routes reset, 001 counter enable, 010 update event.
// - Update interrupt enable at bit 0, update DMA enable at bit 8.
// - Update flag set by update; software clears it writing 0, writing 1 keeps it.
module basic_timebase_timer (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [timebase_pkg::ADDR_W-1:0] paddr,
	input wire logic [timebase_pkg::DATA_W-1:0] pwdata,
	input wire logic slave_update,
	output logic [timebase_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic dma_request,
	output logic trigger_output
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	timebase_pkg::control_one_type control;
	timebase_pkg::request_enable_type enables;
	logic [2:0] trigger_output_select;
	logic update_flag;
	logic [timebase_pkg::COUNT_W-1:0] counter_value;
	logic [timebase_pkg::COUNT_W-1:0] prescale_buffer;
	logic [timebase_pkg::COUNT_W-1:0] prescale_factor;
	logic [timebase_pkg::COUNT_W-1:0] reload_buffer;
	logic [timebase_pkg::COUNT_W-1:0] reload_shadow;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire logic setup_phase = psel & ~penable;
	wire logic write_strobe = psel & penable & pready & pwrite & ~pslverr;
	wire logic hit_ctrl1 = paddr == timebase_pkg::OFS_CONTROL_ONE;
	wire logic hit_ctrl2 = paddr == timebase_pkg::OFS_CONTROL_TWO;
	wire logic hit_enable = paddr == timebase_pkg::OFS_REQUEST_ENABLE;
	wire logic hit_status = paddr == timebase_pkg::OFS_EVENT_STATUS;
	wire logic hit_generate = paddr == timebase_pkg::OFS_EVENT_GENERATE;
	wire logic hit_count = paddr == timebase_pkg::OFS_COUNT_VALUE;
	wire logic hit_prescale = paddr == timebase_pkg::OFS_PRESCALE_VALUE;
	wire logic hit_reload = paddr == timebase_pkg::OFS_RELOAD_VALUE;
	wire logic mapped = hit_ctrl1 | hit_ctrl2 | hit_enable | hit_status | hit_generate
		| hit_count | hit_prescale | hit_reload;

	wire logic write_ctrl1 = write_strobe & hit_ctrl1;
	wire logic write_ctrl2 = write_strobe & hit_ctrl2;
	wire logic write_enable = write_strobe & hit_enable;
	wire logic write_status = write_strobe & hit_status;
	wire logic write_count = write_strobe & hit_count;
	wire logic write_prescale = write_strobe & hit_prescale;
	wire logic write_reload = write_strobe & hit_reload;

	// ------------------------------------------------------------
	// Timebase events
	// ------------------------------------------------------------
	wire logic software_update_generate = write_strobe & hit_generate
		& pwdata[timebase_pkg::UPDATE_GEN_BIT];
	wire logic count_tick;
	wire logic [timebase_pkg::COUNT_W-1:0] reload_limit;
	wire logic at_limit;
	wire logic overflow;
	wire logic update_event;
	wire logic flag_event;
	wire logic flag_clear;

	// Clock, run gate and the divider clear all feed the prescaler directly.
	timebase_prescaler prescaler (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.run(control.run),
		.clear(software_update_generate),
		.factor(prescale_factor),
		.tick(count_tick)
	);

	assign reload_limit = control.reload_buffer ? reload_shadow : reload_buffer;
	assign at_limit = counter_value == reload_limit;
	assign overflow = count_tick & at_limit;
	assign update_event = ~control.update_block
		& (overflow | software_update_generate | slave_update);
	assign flag_event = update_event & (~control.source_select | overflow);
	assign flag_clear = write_status & ~pwdata[timebase_pkg::FLAG_BIT];

	// ------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------
	// The software update outranks a bus write to the counter in the same cycle.
	wire logic [timebase_pkg::COUNT_W-1:0] next_counter_value =
		software_update_generate ? timebase_pkg::COUNT_RESET :
		write_count ? pwdata[timebase_pkg::COUNT_W-1:0] :
		overflow ? timebase_pkg::COUNT_RESET :
		count_tick ? counter_value + timebase_pkg::COUNT_STEP :
		counter_value;

	// A flag set in the clearing cycle survives the clear.
	wire logic next_update_flag = flag_event | (update_flag & ~flag_clear);

	wire logic next_trigger =
		(trigger_output_select == timebase_pkg::TRG_RESET) ? software_update_generate :
		(trigger_output_select == timebase_pkg::TRG_ENABLE) ? control.run :
		(trigger_output_select == timebase_pkg::TRG_UPDATE) ? update_event :
		1'b0;

	wire timebase_pkg::control_one_type written_control = '{
		reload_buffer: pwdata[timebase_pkg::RELOAD_BUF_BIT],
		one_shot: pwdata[timebase_pkg::ONE_SHOT_BIT],
		source_select: pwdata[timebase_pkg::SOURCE_BIT],
		update_block: pwdata[timebase_pkg::BLOCK_BIT],
		run: pwdata[timebase_pkg::RUN_BIT]
	};

	// ------------------------------------------------------------
	// Read selection
	// ------------------------------------------------------------
	wire logic [timebase_pkg::DATA_W-1:0] read_control = {24'h000000,
		control.reload_buffer, 3'h0, control.one_shot, control.source_select,
		control.update_block, control.run};
	wire logic [timebase_pkg::DATA_W-1:0] read_select = {25'h0000000,
		trigger_output_select, 4'h0};
	wire logic [timebase_pkg::DATA_W-1:0] read_enable = {23'h000000,
		enables.update_dma_enable, 7'h00, enables.update_irq_enable};
	wire logic [timebase_pkg::DATA_W-1:0] read_data =
		hit_ctrl1 ? read_control :
		hit_ctrl2 ? read_select :
		hit_enable ? read_enable :
		hit_status ? {31'h00000000, update_flag} :
		hit_count ? {16'h0000, counter_value} :
		hit_prescale ? {16'h0000, prescale_buffer} :
		hit_reload ? {16'h0000, reload_buffer} :
		32'h00000000;

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	// One wait-free access phase: the answer is prepared during setup.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup_phase;
			pslverr <= setup_phase & ~mapped;
			prdata <= (setup_phase & ~pwrite) ? read_data : 32'h00000000;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			control <= timebase_pkg::CONTROL_ONE_RESET;
			trigger_output_select <= timebase_pkg::TRG_RESET;
			enables <= '0;
		end else begin
			if (write_ctrl1) begin
				control <= written_control;
			end
			if (update_event && control.one_shot) begin
				control.run <= 1'b0;
			end
			if (write_ctrl2) begin
				trigger_output_select <=
					pwdata[timebase_pkg::TRG_SEL_MSB:timebase_pkg::TRG_SEL_LSB];
			end
			if (write_enable) begin
				enables.update_irq_enable <= pwdata[timebase_pkg::IRQ_EN_BIT];
				enables.update_dma_enable <= pwdata[timebase_pkg::DMA_EN_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Timebase registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			counter_value <= timebase_pkg::COUNT_RESET;
			prescale_buffer <= timebase_pkg::COUNT_RESET;
			prescale_factor <= timebase_pkg::COUNT_RESET;
			reload_buffer <= timebase_pkg::LIMIT_RESET;
			reload_shadow <= timebase_pkg::LIMIT_RESET;
		end else begin
			counter_value <= next_counter_value;
			if (write_prescale) begin
				prescale_buffer <= pwdata[timebase_pkg::COUNT_W-1:0];
			end
			if (write_reload) begin
				reload_buffer <= pwdata[timebase_pkg::COUNT_W-1:0];
			end
			if (update_event) begin
				prescale_factor <= prescale_buffer;
				reload_shadow <= reload_buffer;
			end
		end
	end

	// ------------------------------------------------------------
	// Status, requests and trigger
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			update_flag <= 1'b0;
			irq <= 1'b0;
			dma_request <= 1'b0;
			trigger_output <= 1'b0;
		end else begin
			update_flag <= next_update_flag;
			irq <= next_update_flag & enables.update_irq_enable;
			dma_request <= flag_event & enables.update_dma_enable;
			trigger_output <= next_trigger;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking checks @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	a_count_frozen: assert property (
		!control.run && !write_count && !software_update_generate |=> $stable(counter_value)
	) else $error("Counter moved while stopped.");

	a_count_wrap: assert property (
		overflow && !software_update_generate && !write_count |=> counter_value == 16'h0000
	) else $error("Counter did not wrap to zero at the limit.");

	a_count_step: assert property (
		count_tick && !at_limit && !software_update_generate && !write_count
		|=> counter_value == $past(counter_value) + 16'h0001
	) else $error("Counter did not step up by one.");

	a_tick_spacing: assert property (
		count_tick && prescale_factor != 16'h0000 && !update_event |=> !count_tick
	) else $error("Prescaler ticked on back-to-back cycles.");

	a_blocked_update: assert property (
		control.update_block |-> !update_event && !flag_event
	) else $error("Update occurred while blocked.");

	a_source_overflow: assert property (
		control.source_select && flag_event |-> overflow
	) else $error("Non-overflow update raised the flag.");

	a_one_shot_stop: assert property (
		update_event && control.one_shot |=> !control.run
	) else $error("One-shot update left the counter running.");

	a_buffer_load: assert property (
		update_event |=> prescale_factor == $past(prescale_buffer)
			&& reload_shadow == $past(reload_buffer)
	) else $error("Buffered values not loaded at update.");

	a_flag_set: assert property (
		flag_event |=> update_flag ##1 (irq == enables.update_irq_enable || !update_flag)
	) else $error("Update flag or interrupt missing after update.");

	a_trigger_update: assert property (
		trigger_output_select == timebase_pkg::TRG_UPDATE && update_event |=> trigger_output
	) else $error("Trigger output missed the update event.");

	a_reset_control: assert property (
		$past(sys_rst) |-> control == timebase_pkg::CONTROL_ONE_RESET
	) else $error("Control register one not zero after reset.");

	a_stopped_divider: assert property (
		!control.run && !software_update_generate |=> $stable(prescaler.divider)
	) else $error("Prescaler divider moved while stopped.");

	a_run_ticks: assert property (
		control.run && prescale_factor == timebase_pkg::COUNT_RESET && !update_event
		|=> count_tick || !control.run
	) else $error("Running counter with undivided clock missed a tick.");

	a_software_zero: assert property (
		software_update_generate |=> counter_value == timebase_pkg::COUNT_RESET
	) else $error("Software update did not zero the counter.");

	a_prescale_held: assert property (
		write_prescale && !update_event |=> prescale_factor == $past(prescale_factor)
	) else $error("Prescale write disturbed the running division.");

	a_reload_held: assert property (
		control.reload_buffer && !update_event && !write_ctrl1 |=> $stable(reload_limit)
	) else $error("Buffered reload limit changed before an update.");

	a_irq_flag: assert property (
		irq |-> update_flag
	) else $error("Interrupt high without the update flag.");

	a_dma_pulse: assert property (
		flag_event && enables.update_dma_enable |=> dma_request
	) else $error("DMA request missing after an update.");

	a_trigger_enable: assert property (
		trigger_output_select == timebase_pkg::TRG_ENABLE |=> trigger_output == $past(control.run)
	) else $error("Trigger output does not follow the run bit.");

	a_trigger_reset: assert property (
		trigger_output_select == timebase_pkg::TRG_RESET && software_update_generate |=> trigger_output
	) else $error("Trigger output missed the software update.");

	a_flag_cleared: assert property (
		flag_clear && !flag_event |=> !update_flag
	) else $error("Update flag survived a clear.");

	a_flag_kept: assert property (
		update_flag && !flag_clear |=> update_flag
	) else $error("Update flag dropped without a clear.");

	c_overflow: cover property (overflow ##1 update_flag);
	c_one_shot: cover property (control.one_shot && update_event ##1 !control.run);
	c_software_update: cover property (software_update_generate && control.run);
	c_flag_clear: cover property (update_flag && flag_clear ##1 !update_flag);
	c_slave_update: cover property (slave_update && update_event);

endmodule // basic_timebase_timer

`default_nettype wire

// file: src/timebase_pkg.sv
// Shared constants and types of the basic up-counting timebase timer.
package timebase_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned COUNT_W = 16;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_REQUEST_ENABLE = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EVENT_GENERATE = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_COUNT_VALUE = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_PRESCALE_VALUE = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_RELOAD_VALUE = 8'h2c;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned RUN_BIT = 0;
	localparam int unsigned BLOCK_BIT = 1;
	localparam int unsigned SOURCE_BIT = 2;
	localparam int unsigned ONE_SHOT_BIT = 3;
	localparam int unsigned RELOAD_BUF_BIT = 7;
	localparam int unsigned TRG_SEL_LSB = 4;
	localparam int unsigned TRG_SEL_MSB = 6;
	localparam int unsigned IRQ_EN_BIT = 0;
	localparam int unsigned DMA_EN_BIT = 8;
	localparam int unsigned FLAG_BIT = 0;
	localparam int unsigned UPDATE_GEN_BIT = 0;

	// ------------------------------------------------------------
	// Trigger output selections and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] TRG_RESET = 3'h0;
	localparam logic [2:0] TRG_ENABLE = 3'h1;
	localparam logic [2:0] TRG_UPDATE = 3'h2;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_STEP = 16'h0001;
	localparam logic [COUNT_W-1:0] LIMIT_RESET = 16'hffff;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic reload_buffer;
		logic one_shot;
		logic source_select;
		logic update_block;
		logic run;
	} control_one_type;

	localparam control_one_type CONTROL_ONE_RESET = 5'h00;

	typedef struct packed {
		logic update_irq_enable;
		logic update_dma_enable;
	} request_enable_type;

endpackage

// file: src/timebase_prescaler.sv
// Programmable prescaler that turns the timer clock into count ticks.
`timescale 1ns/100ps
`default_nettype none

module timebase_prescaler (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic clear,
	input wire logic [timebase_pkg::COUNT_W-1:0] factor,
	output logic tick
);

	logic [timebase_pkg::COUNT_W-1:0] divider;

	// A factor lowered at an update can leave the divider above it, so compare with >=.
	assign tick = run & (divider >= factor);

	always_ff @(posedge clk_sys) begin
		if (sys_rst || clear) begin
			divider <= timebase_pkg::COUNT_RESET;
		end else if (run) begin
			divider <= tick ? timebase_pkg::COUNT_RESET : divider + timebase_pkg::COUNT_STEP;
		end
	end

endmodule // timebase_prescaler

`default_nettype wire

// file: tb/basic_upcount_timebase_timer_tb_top.sv
// Self-checking bench of the basic timebase timer.
`timescale 1ns/100ps
`default_nettype none

module basic_upcount_timebase_timer_tb_top;
	logic clk_sys, sys_rst, psel, penable, pwrite, slave_update, err;
	logic [timebase_pkg::ADDR_W-1:0] paddr;
	logic [timebase_pkg::DATA_W-1:0] pwdata, prdata, rd;
	logic pready, pslverr, irq, dma_request, trigger_output;
	int failures, tests_run, trig_count, dma_count, period, t0, d0, p, l;

	basic_timebase_timer i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.slave_update(slave_update), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .dma_request(dma_request), .trigger_output(trigger_output));
	timer_partner i_far (.clk_sys(clk_sys), .irq(irq), .dma_request(dma_request),
		.trigger_output(trigger_output), .trig_count(trig_count), .dma_count(dma_count),
		.period(period));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task print_verdict;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
			failures++;
		end
	endtask

	// The request is held until pready is seen high; after 20 access cycles without it the run is failed.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			print_verdict;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h00000000);
		chk(rd, exp, m);
	endtask

	task wait_trig(input int k);
		int n;
		n = 0;
		t0 = trig_count;
		while (trig_count < t0 + k && n < 20000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 20000) begin
			failures++;
			print_verdict;
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		slave_update = 1'b0;
		failures = 0;
		tests_run = 0;
		void'($urandom(64548));
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdchk(timebase_pkg::OFS_CONTROL_ONE, 32'h00000000, "ctrl reset");
		rdchk(timebase_pkg::OFS_RELOAD_VALUE, 32'h0000ffff, "reload reset");
		rdchk(timebase_pkg::OFS_COUNT_VALUE, 32'h00000000, "count reset");
		chk(err, 1'b0, "mapped err");
		apb(1'b0, 8'h30, 32'h00000000);
		chk(err, 1'b1, "unmapped err");
		chk(rd, 32'h00000000, "unmapped data");
		p = $urandom_range(3, 0);
		l = $urandom_range(9, 2);
		wr(timebase_pkg::OFS_PRESCALE_VALUE, p);
		wr(timebase_pkg::OFS_RELOAD_VALUE, l);
		wr(timebase_pkg::OFS_EVENT_GENERATE, 32'h00000001);
		wr(timebase_pkg::OFS_CONTROL_TWO, 32'h00000020);
		wr(timebase_pkg::OFS_REQUEST_ENABLE, 32'h00000101);
		d0 = dma_count;
		wr(timebase_pkg::OFS_CONTROL_ONE, 32'h00000001);
		wait_trig(3);
		chk(period, (p + 1) * (l + 1), "period");
		chk(dma_count - d0, 3, "dma pulses");
		chk(irq, 1'b1, "irq");
		p = $urandom_range(3, 0);
		wr(timebase_pkg::OFS_PRESCALE_VALUE, p);
		wait_trig(3);
		chk(period, (p + 1) * (l + 1), "new prescale");
		l = $urandom_range(9, 2);
		wr(timebase_pkg::OFS_CONTROL_ONE, 32'h00000081);
		wr(timebase_pkg::OFS_RELOAD_VALUE, l);
		rdchk(timebase_pkg::OFS_RELOAD_VALUE, l, "reload read");
		wait_trig(3);
		chk(period, (p + 1) * (l + 1), "new reload");
		wr(timebase_pkg::OFS_CONTROL_ONE, 32'h00000000);
		wr(timebase_pkg::OFS_EVENT_STATUS, 32'h00000001);
		rdchk(timebase_pkg::OFS_EVENT_STATUS, 32'h00000001, "flag kept");
		wr(timebase_pkg::OFS_EVENT_STATUS, 32'h00000000);
		rdchk(timebase_pkg::OFS_EVENT_STATUS, 32'h00000000, "flag cleared");
		chk(irq, 1'b0, "irq low");
		wr(timebase_pkg::OFS_COUNT_VALUE, 32'h00000005);
		repeat (6) @(posedge clk_sys);
		rdchk(timebase_pkg::OFS_COUNT_VALUE, 32'h00000005, "count holds");
		wr(timebase_pkg::OFS_CONTROL_ONE, 32'h00000002);
		wr(timebase_pkg::OFS_EVENT_GENERATE, 32'h00000001);
		rdchk(timebase_pkg::OFS_COUNT_VALUE, 32'h00000000, "sw zero");
		rdchk(timebase_pkg::OFS_EVENT_STATUS, 32'h00000000, "blocked");
		wr(timebase_pkg::OFS_CONTROL_ONE, 32'h00000004);
		d0 = dma_count;
		wr(timebase_pkg::OFS_EVENT_GENERATE, 32'h00000001);
		repeat (3) @(posedge clk_sys);
		chk(dma_count - d0, 0, "source overflow only");
		wr(timebase_pkg::OFS_CONTROL_ONE, 32'h00000000);
		wr(timebase_pkg::OFS_EVENT_STATUS, 32'h00000000);
		d0 = dma_count;
		wr(timebase_pkg::OFS_EVENT_GENERATE, 32'h00000001);
		rdchk(timebase_pkg::OFS_EVENT_STATUS, 32'h00000001, "sw flag");
		chk(dma_count - d0, 1, "sw dma");
		wr(timebase_pkg::OFS_EVENT_STATUS, 32'h00000000);
		@(posedge clk_sys);
		slave_update <= 1'b1;
		@(posedge clk_sys);
		slave_update <= 1'b0;
		rdchk(timebase_pkg::OFS_EVENT_STATUS, 32'h00000001, "slave flag");
		wr(timebase_pkg::OFS_CONTROL_ONE, 32'h00000009);
		wait_trig(1);
		rdchk(timebase_pkg::OFS_CONTROL_ONE, 32'h00000008, "one shot");
		repeat (10) @(posedge clk_sys);
		rdchk(timebase_pkg::OFS_COUNT_VALUE, 32'h00000000, "stopped");
		wr(timebase_pkg::OFS_CONTROL_TWO, 32'h00000010);
		wr(timebase_pkg::OFS_CONTROL_ONE, 32'h00000001);
		repeat (2) @(posedge clk_sys);
		chk(trigger_output, 1'b1, "trg run");
		wr(timebase_pkg::OFS_CONTROL_ONE, 32'h00000000);
		repeat (2) @(posedge clk_sys);
		chk(trigger_output, 1'b0, "trg stop");
		wr(timebase_pkg::OFS_CONTROL_TWO, 32'h00000000);
		d0 = trig_count;
		wr(timebase_pkg::OFS_EVENT_GENERATE, 32'h00000001);
		repeat (3) @(posedge clk_sys);
		chk(trig_count - d0, 1, "trg sw");
		print_verdict;
	end
endmodule // basic_upcount_timebase_timer_tb_top

`default_nettype wire

// file: tb/timer_partner.sv
// Far-side model of the timer: trigger and DMA consumers; the interrupt input is left unused.
`timescale 1ns/100ps
`default_nettype none

module timer_partner (
	input wire logic clk_sys,
	input wire logic irq,
	input wire logic dma_request,
	input wire logic trigger_output,
	output var int trig_count,
	output var int dma_count,
	output var int period
);
	// ----------------------------------------
	// Event capture
	// ----------------------------------------
	// Only rising edges of the trigger are counted, so a level selection counts once.
	int cyc;
	int last;
	logic trig_d;
	initial begin
		cyc = 0;
		last = 0;
		trig_d = 1'b0;
		trig_count = 0;
		dma_count = 0;
		period = 0;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		trig_d <= trigger_output;
		if (trigger_output === 1'b1 && trig_d !== 1'b1) begin
			trig_count <= trig_count + 1;
			period <= cyc - last;
			last <= cyc;
		end
		if (dma_request === 1'b1) begin
			dma_count <= dma_count + 1;
		end
	end
endmodule // timer_partner

`default_nettype wire
